/* shared/osr_pkg.sv */
`default_nettype none
package osr_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int ADDR_W = 12;
    localparam int NUM_CH = 4;
    localparam int DRV_PER_CH = 3;
    localparam int NUM_DRV = NUM_CH * DRV_PER_CH;

    localparam logic [11:0] ADDR_SERIAL    = 12'h000;
    localparam logic [11:0] ADDR_DRV_FIRST = 12'h0f0;
    localparam logic [11:0] ADDR_DRV_LAST  = 12'h0fb;
    localparam logic [11:0] ADDR_DIST      = 12'h230;
    localparam logic [11:0] ADDR_UPDATE    = 12'h232;
    localparam logic [11:0] ADDR_EE_CTL    = 12'hb02;

    localparam int SER_SOFT_RST_LO = 2;
    localparam int SER_SOFT_RST_HI = 5;
    localparam int DIST_SOFT_SYNC  = 0;
    localparam int DIST_PD         = 1;
    localparam int UPDATE_BIT      = 0;
    localparam int EE_RELOAD_BIT   = 1;
    localparam int DRV_PD          = 0;
    localparam int DRV_POL_A       = 1;
    localparam int DRV_POL_B       = 2;
    localparam int DRV_CMOS        = 3;
    localparam int DRV_EN_A        = 5;
    localparam int DRV_EN_B        = 6;

    localparam logic [7:0] SER_RST  = 8'h00;
    localparam logic [7:0] DRV_RST  = 8'h60;
    localparam logic [7:0] DIST_RST = 8'h00;
    localparam logic [7:0] RD_NONE  = 8'h00;
    // pin sync order {eeprom_sel, sleep, hw_reset, strobe}; idle levels
    localparam logic [3:0] PIN_RST  = 4'h7;

    // strobe release to first output edge, in divider input cycles
    localparam int SYNC_PIPE_MIN = 14;
    localparam int SYNC_EXTRA    = 1;
    localparam int SYNC_OVH      = 2;
    localparam logic [5:0] SYNC_LOAD =
        6'(SYNC_PIPE_MIN + SYNC_EXTRA - SYNC_OVH);
    localparam logic [4:0] PH_WIDE = 5'h10;
    localparam logic [4:0] PH_ONE  = 5'h01;

    localparam int POR_WAIT_MS  = 70;
    localparam int EE_WAIT_MS   = 20;
    localparam int NOEE_WAIT_US = 2;
    localparam int WAIT_W = 22;
    localparam int POR_WAIT_CYC = POR_WAIT_MS * (CLK_HZ / 1000);
    localparam int EE_WAIT_CYC  = EE_WAIT_MS * (CLK_HZ / 1000);
    localparam int NOEE_WAIT_CYC = NOEE_WAIT_US * (CLK_HZ / 1_000_000);

    typedef enum logic [1:0] {
        OSR_RF_POR,
        OSR_RF_HOLD,
        OSR_RF_WAIT,
        OSR_RF_IDLE
    } osr_rflow_t;
endpackage
`default_nettype wire

/* design/osr_sync_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none

// Contract
// - per-channel bit excludes channel from sync
// - strobe low then released aligns outputs
// - soft sync, soft reset, dist pd trigger sync
// - reset pin and sleep pin pulses sync
// - VCO calibration holds sync while running
// - outputs start 14-15 plus one cycles later
// - strobe sampled asynchronously, one cycle jitter
// - soft sync changes act only on update
// - held outputs sit at start-high, resume phased
// - new phase offset waits for a sync
// - four dividers each feed three drivers
// - ignored channels keep toggling through sync
// - differential polarity and power-down per output
// - single-ended mode: both halves on, independent
// - two enable bits tristate single-ended drivers
// - power-on loads EEPROM or defaults by pin; here always defaults, select sync still at its reset 0
// - power-on sync, outputs after about 70 ms
// - reset pin restores settings and syncs
// - reset resume 2 us, or 20 ms with EEPROM
// - both soft-reset bits restore by select pin
// - soft-reset bits self-clear, hold till serial tick
// - EEPROM reload bit, only with select high
// - coarse delay from start-high, offset, low count
module osr_sync_ctrl #(
    parameter int POR_WAIT = osr_pkg::POR_WAIT_CYC,
    parameter int EE_WAIT  = osr_pkg::EE_WAIT_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        sync_strobe_n,
    input  wire logic        hw_reset_n,
    input  wire logic        sleep_request_n,
    input  wire logic        eeprom_sel,
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    input  wire logic [11:0] reg_addr,
    input  wire logic [7:0]  reg_wr_data,
    output logic      [7:0]  reg_rd_data,
    input  wire logic        serial_clk_tick,
    input  wire logic        vco_cal_busy,
    input  wire logic [3:0]  ignore_sync,
    input  wire logic [3:0]  start_high_level,
    input  wire logic [15:0] phase_offset_count,
    input  wire logic [15:0] low_cycles,
    input  wire logic [15:0] high_cycles,
    output logic      [11:0] out_a,
    output logic      [11:0] out_a_oe,
    output logic      [11:0] out_b,
    output logic      [11:0] out_b_oe,
    output logic             sync_active,
    output logic             restore_eeprom,
    output logic             restore_defaults,
    output logic             reset_busy
);
    import osr_pkg::*;

    typedef struct packed {
        logic [3:0]             pin_m;
        logic [3:0]             pin_s;
        logic [7:0]             ser_cfg;
        logic                   soft_hold;
        logic [NUM_DRV-1:0][7:0] drv_cfg;
        logic [7:0]             dist_stage;
        logic [7:0]             dist_act;
        logic                   ee_reload;
        osr_rflow_t             rflow;
        logic [WAIT_W-1:0]      wait_cnt;
        logic                   restore_ee;
        logic                   restore_def;
        logic [7:0]             rd_data;
        logic                   sync_act;
        logic [NUM_CH-1:0][5:0] dly;
        logic [NUM_CH-1:0][4:0] cnt;
        logic [NUM_CH-1:0]      lvl;
        logic [11:0]            oa;
        logic [11:0]            oa_oe;
        logic [11:0]            ob;
        logic [11:0]            ob_oe;
    } osr_state_t;

    osr_state_t s;
    osr_state_t n;

    logic              strobe_s;
    logic              hwrst_s;
    logic              sleep_s;
    logic              ee_s;
    logic [11:0]       drv_off;
    logic [3:0]        drv_idx;
    logic              drv_hit;
    logic [NUM_CH-1:0][5:0] coarse;

    // only the second stage is read by logic
    assign strobe_s = s.pin_s[0];
    assign hwrst_s  = s.pin_s[1];
    assign sleep_s  = s.pin_s[2];
    assign ee_s     = s.pin_s[3];

    assign drv_off = reg_addr - ADDR_DRV_FIRST;
    assign drv_idx = drv_off[3:0];
    assign drv_hit = (reg_addr >= ADDR_DRV_FIRST)
                  && (reg_addr <= ADDR_DRV_LAST);

    // coarse delay per channel from live start-high and offset
    for (genvar c = 0; c < NUM_CH; c++) begin : g_coarse
        logic [4:0] phi;
        logic [4:0] wide;
        assign phi = {start_high_level[c], phase_offset_count[4*c +: 4]};
        assign wide = {1'b0, phase_offset_count[4*c +: 4]}
                    + {1'b0, low_cycles[4*c +: 4]} + PH_ONE;
        assign coarse[c] = (phi < PH_WIDE) ? {1'b0, phi}
                                           : {1'b0, wide};
    end

    always_comb begin
        logic do_restore;
        logic sync_req;
        int   ch;
        do_restore = 1'b0;
        sync_req = 1'b0;
        ch = 0;
        n = s;
        n.restore_ee = 1'b0;
        n.restore_def = 1'b0;
        n.ee_reload = 1'b0;
        n.pin_m = {eeprom_sel, sleep_request_n, hw_reset_n, sync_strobe_n};
        n.pin_s = s.pin_m;

        // soft reset stays until one more serial clock arrives
        if (s.soft_hold && serial_clk_tick) begin
            n.soft_hold = 1'b0;
        end

        if (reg_wr_en) begin
            unique case (reg_addr)
                ADDR_SERIAL: begin
                    if (reg_wr_data[SER_SOFT_RST_LO]
                        && reg_wr_data[SER_SOFT_RST_HI]) begin
                        n.soft_hold = 1'b1;
                        do_restore = 1'b1;
                    end else begin
                        n.ser_cfg = reg_wr_data;
                        n.ser_cfg[SER_SOFT_RST_LO] = 1'b0;
                        n.ser_cfg[SER_SOFT_RST_HI] = 1'b0;
                    end
                end
                ADDR_DIST: begin
                    n.dist_stage = reg_wr_data;
                end
                ADDR_UPDATE: begin
                    if (reg_wr_data[UPDATE_BIT]) begin
                        n.dist_act = s.dist_stage;
                    end
                end
                ADDR_EE_CTL: begin
                    // reload is ignored with the select pin low
                    if (reg_wr_data[EE_RELOAD_BIT] && ee_s) begin
                        n.ee_reload = 1'b1;
                        do_restore = 1'b1;
                        n.rflow = OSR_RF_WAIT;
                        n.wait_cnt = WAIT_W'(EE_WAIT);
                    end
                end
                default: begin
                    if (drv_hit) begin
                        n.drv_cfg[drv_idx] = reg_wr_data;
                    end
                end
            endcase
        end

        if (reg_rd_en) begin
            n.rd_data = RD_NONE;
            unique case (reg_addr)
                ADDR_SERIAL: begin
                    n.rd_data = s.ser_cfg;
                    n.rd_data[SER_SOFT_RST_LO] = s.soft_hold;
                    n.rd_data[SER_SOFT_RST_HI] = s.soft_hold;
                end
                ADDR_DIST: begin
                    n.rd_data = s.dist_stage;
                end
                ADDR_UPDATE: begin
                    n.rd_data = RD_NONE;
                end
                ADDR_EE_CTL: begin
                    n.rd_data[EE_RELOAD_BIT] = s.ee_reload;
                end
                default: begin
                    if (drv_hit) begin
                        n.rd_data = s.drv_cfg[drv_idx];
                    end
                end
            endcase
        end

        // reset flow; the strap picks the restore source on entry to reset and the wait length after release
        if (!hwrst_s) begin
            n.rflow = OSR_RF_HOLD;
            if (s.rflow != OSR_RF_HOLD) begin
                do_restore = 1'b1;
            end
        end else begin
            unique case (s.rflow)
                OSR_RF_POR: begin
                    do_restore = 1'b1;
                    n.rflow = OSR_RF_WAIT;
                    n.wait_cnt = WAIT_W'(POR_WAIT);
                end
                OSR_RF_HOLD: begin
                    n.rflow = OSR_RF_WAIT;
                    n.wait_cnt = ee_s ? WAIT_W'(EE_WAIT)
                                      : WAIT_W'(NOEE_WAIT_CYC);
                end
                OSR_RF_WAIT: begin
                    if (s.wait_cnt == '0) begin
                        n.rflow = OSR_RF_IDLE;
                    end else if (!reg_wr_en
                                 || reg_addr != ADDR_EE_CTL
                                 || !n.ee_reload) begin
                        n.wait_cnt = s.wait_cnt - 1'b1;
                    end
                end
                OSR_RF_IDLE: begin
                end
            endcase
        end

        // settings come back from EEPROM or on-chip defaults
        if (do_restore) begin
            n.restore_ee = ee_s;
            n.restore_def = !ee_s;
            n.drv_cfg = {NUM_DRV{DRV_RST}};
            n.dist_stage = DIST_RST;
            n.dist_act = DIST_RST;
        end

        sync_req = (s.rflow != OSR_RF_IDLE)
                 || !strobe_s
                 || s.dist_act[DIST_SOFT_SYNC]
                 || s.dist_act[DIST_PD]
                 || s.soft_hold
                 || !sleep_s
                 || vco_cal_busy;
        n.sync_act = sync_req;

        // divider run; held channels reload start delay every cycle
        for (int c = 0; c < NUM_CH; c++) begin
            if (s.sync_act && !ignore_sync[c]) begin
                n.dly[c] = SYNC_LOAD + coarse[c];
                n.lvl[c] = start_high_level[c];
                n.cnt[c] = '0;
            end else if (s.dly[c] != '0) begin
                n.dly[c] = s.dly[c] - 1'b1;
                if (s.dly[c] == 6'h01) begin
                    n.lvl[c] = 1'b1;
                    n.cnt[c] = {1'b0, high_cycles[4*c +: 4]};
                end
            end else if (s.cnt[c] == '0) begin
                n.lvl[c] = !s.lvl[c];
                n.cnt[c] = s.lvl[c] ? {1'b0, low_cycles[4*c +: 4]}
                                    : {1'b0, high_cycles[4*c +: 4]};
            end else begin
                n.cnt[c] = s.cnt[c] - 1'b1;
            end
        end

        // drivers; sleep tristates everything
        for (int d = 0; d < NUM_DRV; d++) begin
            ch = d / DRV_PER_CH;
            n.oa[d] = s.lvl[ch] ^ s.drv_cfg[d][DRV_POL_A];
            if (s.drv_cfg[d][DRV_CMOS]) begin
                n.ob[d] = s.lvl[ch] ^ s.drv_cfg[d][DRV_POL_B];
                n.oa_oe[d] = sleep_s && s.drv_cfg[d][DRV_EN_A];
                n.ob_oe[d] = sleep_s && s.drv_cfg[d][DRV_EN_B];
            end else begin
                n.ob[d] = !n.oa[d];
                n.oa_oe[d] = sleep_s && !s.drv_cfg[d][DRV_PD];
                n.ob_oe[d] = n.oa_oe[d];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s <= '0;
            s.pin_m <= PIN_RST;
            s.pin_s <= PIN_RST;
            s.ser_cfg <= SER_RST;
            s.drv_cfg <= {NUM_DRV{DRV_RST}};
            s.dist_stage <= DIST_RST;
            s.dist_act <= DIST_RST;
            s.rflow <= OSR_RF_POR;
            s.sync_act <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign reg_rd_data = s.rd_data;
    assign out_a = s.oa;
    assign out_a_oe = s.oa_oe;
    assign out_b = s.ob;
    assign out_b_oe = s.ob_oe;
    assign sync_active = s.sync_act;
    assign restore_eeprom = s.restore_ee;
    assign restore_defaults = s.restore_def;
    assign reset_busy = (s.rflow != OSR_RF_IDLE) || s.soft_hold;
endmodule // osr_sync_ctrl

`default_nettype wire

/* verif/osr_sync_props.sv */
`timescale 1ns/10ps
`default_nettype none
module osr_sync_props
    import osr_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        sleep_request_n,
    input wire logic        hw_reset_n,
    input wire logic        eeprom_sel,
    input wire logic        reg_wr_en,
    input wire logic        reg_rd_en,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0]  reg_wr_data,
    input wire logic [7:0]  reg_rd_data,
    input wire logic        serial_clk_tick,
    input wire logic [3:0]  ignore_sync,
    input wire logic [3:0]  start_high_level,
    input wire logic [15:0] phase_offset_count,
    input wire logic [11:0] out_a,
    input wire logic [11:0] out_a_oe,
    input wire logic [11:0] out_b_oe,
    input wire logic        sync_active,
    input wire logic        restore_eeprom,
    input wire logic        restore_defaults,
    input wire logic        reset_busy
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_soft_wr;
        reg_wr_en && reg_addr == ADDR_SERIAL
            && reg_wr_data[SER_SOFT_RST_HI] && reg_wr_data[SER_SOFT_RST_LO];
    endsequence
    // coarse delay zero: first edge only after the full pipeline
    sequence s_quiet;
        !out_a[0] [*8] ##1 !out_a[0] [*4];
    endsequence
    upd_zero_a: assert property (
        reg_rd_en && reg_addr == ADDR_UPDATE |=> reg_rd_data == 8'h00)
        else $error("update register read not zero");
    sleep_tri_a: assert property (
        !sleep_request_n [*5] |-> out_a_oe == 12'h000 && out_b_oe == 12'h000)
        else $error("outputs driven in sleep");
    hw_hold_a: assert property (
        !hw_reset_n [*5] |-> reset_busy && sync_active)
        else $error("reset pin low without hold");
    pulse_once_a: assert property (
        restore_eeprom || restore_defaults
        |=> !restore_eeprom && !restore_defaults)
        else $error("restore pulse too long");
    ee_gate_a: assert property (
        !eeprom_sel [*4] |-> !restore_eeprom)
        else $error("stored settings loaded with select low");
    soft_rst_a: assert property (
        s_soft_wr |=> restore_eeprom || restore_defaults)
        else $error("soft reset without restore");
    soft_hold_a: assert property (
        s_soft_wr ##1 !serial_clk_tick [*4] |-> reset_busy && sync_active)
        else $error("soft reset released before serial tick");
    sync_delay_a: assert property (
        $fell(sync_active) && !ignore_sync[0] && !start_high_level[0]
        && phase_offset_count[3:0] == 4'h0 |-> s_quiet ##[1:3] out_a[0])
        else $error("sync release to first edge off");
    held_static_a: assert property (
        sync_active [*4] ##0 !ignore_sync[0] |-> $stable(out_a[0]))
        else $error("held output moved");
endmodule // osr_sync_props
bind osr_sync_ctrl osr_sync_props i_osr_sync_props (.*);
`default_nettype wire

/* verif/osr_host_pins.sv */
`timescale 1ns/10ps
`default_nettype none
module osr_host_pins (
    input  wire logic       clk_sys,
    input  wire logic       go,
    input  wire logic [1:0] pin_sel,
    input  wire logic [7:0] low_len,
    output logic            sync_strobe_n,
    output logic            hw_reset_n,
    output logic            sleep_request_n,
    output logic            busy
);
    logic [7:0] cnt;
    initial begin
        {sync_strobe_n, hw_reset_n, sleep_request_n} = 3'h7;
        busy = 1'b0;
        cnt = 8'h00;
    end
    // one pin pulled low for low_len+1 cycles, then back to its pull-up
    always @(posedge clk_sys) begin
        if (go && !busy) begin
            busy <= 1'b1;
            cnt <= low_len;
            sync_strobe_n <= (pin_sel != 2'h0);
            hw_reset_n <= (pin_sel != 2'h1);
            sleep_request_n <= (pin_sel != 2'h2);
        end else if (busy && cnt == 8'h00) begin
            busy <= 1'b0;
            {sync_strobe_n, hw_reset_n, sleep_request_n} <= 3'h7;
        end else if (busy) begin
            cnt <= cnt - 8'h01;
        end
    end
endmodule // osr_host_pins
`default_nettype wire

/* verif/osr_sync_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module osr_sync_ctrl_tb;
    import osr_pkg::*;
    logic clk_sys, rst_n, eeprom_sel, reg_wr_en, reg_rd_en, go, busy;
    logic serial_clk_tick, vco_cal_busy, sync_active, reset_busy;
    logic sync_strobe_n, hw_reset_n, sleep_request_n;
    logic restore_eeprom, restore_defaults;
    logic [11:0] reg_addr, out_a, out_a_oe, out_b, out_b_oe;
    logic [7:0]  reg_wr_data, reg_rd_data, low_len;
    logic [3:0]  ignore_sync, start_high_level;
    logic [15:0] phase_offset_count, low_cycles, high_cycles;
    logic [1:0]  pin_sel;
    int          n_errors, tests_run;
    localparam logic [11:0] DRV6 = ADDR_DRV_FIRST + 12'h006;

    osr_sync_ctrl #(.POR_WAIT(20), .EE_WAIT(30)) i_osr_sync_ctrl (.*);
    osr_host_pins i_osr_host_pins (.*);

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic report_and_stop;
        if (n_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        step(1);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wr_data = d;
        step(1);
        reg_wr_en = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        step(1);
        reg_rd_en = 1'b1;
        reg_addr = a;
        step(1);
        reg_rd_en = 1'b0;
        chk(reg_rd_data, exp);
    endtask
    // bounded wait for the hold and any reset flow to end
    task automatic wait_free;
        int i;
        for (i = 0; i < 3000 && (sync_active !== 1'b0
             || reset_busy !== 1'b0); i++) step(1);
        if (i == 3000) begin
            chk(1'b0, 1'b1);
            report_and_stop;
        end
        // let released channels reach their first edge before a new hold
        step(16);
    endtask
    task automatic pulse(input logic [1:0] s, input logic [7:0] n);
        int i;
        step(1);
        pin_sel = s;
        low_len = n;
        go = 1'b1;
        step(1);
        go = 1'b0;
        for (i = 0; i < 300 && busy; i++) step(1);
        if (busy) begin
            chk(1'b0, 1'b1);
            report_and_stop;
        end
    endtask

    task automatic t_regs;
        rd(ADDR_SERIAL, SER_RST);
        rd(ADDR_DRV_LAST, DRV_RST);
        rd(ADDR_DIST, DIST_RST);
        rd(ADDR_UPDATE, 8'h00);
        rd(12'h001, RD_NONE);
    endtask
    task automatic t_strobe;
        int n, tg;
        logic prev;
        tg = 0;
        prev = out_a[3];
        fork
            pulse(2'h0, 8'h10);
            repeat (10) begin
                step(1);
                tg += int'(out_a[3] !== prev);
                prev = out_a[3];
            end
        join
        chk(12'(tg >= 3), 12'h001);
        chk(out_a[6], 1'b1);
        chk(out_b[6], 1'b0);
        for (n = 0; n < 40 && out_a[0] !== 1'b1; n++) step(1);
        chk(12'(n >= 15 && n <= 17), 12'h001);
        wait_free;
    endtask
    // offset of three cycles on channel 0 shifts the first edge by three
    task automatic t_phase;
        int n;
        phase_offset_count = 16'h0003;
        pulse(2'h0, 8'h04);
        for (n = 0; n < 40 && out_a[0] !== 1'b1; n++) step(1);
        chk(12'(n >= 18 && n <= 20), 12'h001);
        phase_offset_count = 16'h0000;
        wait_free;
    endtask
    task automatic t_soft;
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_DIST, 8'(1 << i));
            step(3);
            chk(sync_active, 1'b0);
            wr(ADDR_UPDATE, 8'h01);
            step(3);
            chk(sync_active, 1'b1);
            wr(ADDR_DIST, 8'h00);
            wr(ADDR_UPDATE, 8'h01);
            wait_free;
        end
        vco_cal_busy = 1'b1;
        step(3);
        chk(sync_active, 1'b1);
        vco_cal_busy = 1'b0;
        wait_free;
    endtask
    task automatic t_srst;
        wr(ADDR_SERIAL, 8'h01);
        wr(ADDR_SERIAL, 8'h25);
        chk(restore_defaults, 1'b1);
        rd(ADDR_SERIAL, 8'h25);
        step(3);
        chk(reset_busy, 1'b1);
        serial_clk_tick = 1'b1;
        step(1);
        serial_clk_tick = 1'b0;
        wait_free;
        rd(ADDR_SERIAL, 8'h01);
    endtask
    task automatic t_drv;
        wr(DRV6, 8'h28);
        step(3);
        chk({out_a_oe[6], out_b_oe[6]}, 2'h2);
        wr(DRV6, 8'h68);
        step(3);
        chk({out_a_oe[6], out_b_oe[6]}, 2'h3);
        wr(DRV6, 8'h61);
        step(3);
        chk(out_a_oe[6], 1'b0);
    endtask
    task automatic t_rst;
        logic seen;
        pulse(2'h1, 8'h04);
        step(2);
        chk(reset_busy, 1'b1);
        step(60);
        chk(reset_busy, 1'b1);
        wait_free;
        rd(DRV6, DRV_RST);
        for (int s = 1; s >= 0; s--) begin
            eeprom_sel = s[0];
            step(4);
            wr(ADDR_EE_CTL, 8'h02);
            seen = restore_eeprom;
            repeat (4) begin
                step(1);
                seen |= restore_eeprom;
            end
            chk(seen, s[0]);
            wait_free;
        end
        pulse(2'h2, 8'h08);
        wait_free;
    endtask

    initial begin
        n_errors = 0;
        tests_run = 0;
        rst_n = 1'b0;
        eeprom_sel = 1'b0;
        {reg_wr_en, reg_rd_en, go, serial_clk_tick, vco_cal_busy} = 5'h00;
        reg_addr = 12'h000;
        reg_wr_data = 8'h00;
        pin_sel = 2'h0;
        low_len = 8'h00;
        ignore_sync = 4'h2;
        start_high_level = 4'h4;
        phase_offset_count = 16'h0000;
        low_cycles = 16'h1111;
        high_cycles = 16'h1111;
        step(10);
        rst_n = 1'b1;
        step(1);
        chk(restore_defaults, 1'b1);
        chk(sync_active, 1'b1);
        wait_free;
        t_regs;
        t_strobe;
        t_phase;
        t_soft;
        t_srst;
        t_drv;
        t_rst;
        report_and_stop;
    end
endmodule // osr_sync_ctrl_tb
`default_nettype wire
